// ### nfh_map.svh
`ifndef NFH_MAP_SVH
`define NFH_MAP_SVH

// ==========================================
// Register byte offsets
`define NFH_REG_CTRL 8'h00
`define NFH_REG_ADDR 8'h04
`define NFH_REG_DATA 8'h08
`define NFH_REG_STAT 8'h0c
`define NFH_REG_CFG 8'h10

// ==========================================
// Field positions
`define NFH_CTRL_CMD_MSB 7
`define NFH_CTRL_OP_LSB 8
`define NFH_CTRL_OP_MSB 10
`define NFH_STAT_BUSY 0
`define NFH_STAT_READY 1
`define NFH_STAT_ERR 2
`define NFH_STAT_MULTI 3
`define NFH_CFG_CE 0
`define NFH_CFG_WREN 1
`define NFH_CFG_RST 2'h0
`define NFH_ADDR_BITS 26

// ==========================================
// Command codes
`define NFH_C_READ_A 8'h00
`define NFH_C_READ_B 8'h01
`define NFH_C_READ_CB 8'h03
`define NFH_C_READ_SP 8'h50
`define NFH_C_ID 8'h90
`define NFH_C_RESET 8'hff
`define NFH_C_PROG 8'h80
`define NFH_C_TRUE 8'h10
`define NFH_C_DUMMY 8'h11
`define NFH_C_COPY 8'h8a
`define NFH_C_ERASE 8'h60
`define NFH_C_ERCONF 8'hd0
`define NFH_C_STAT 8'h70
`define NFH_C_MSTAT 8'h71

// ==========================================
// Timing, ns and derived cycle counts (least times round up)
`define NFH_CLK_NS 20
`define NFH_T_SETUP_NS 15
`define NFH_T_WP_NS 25
`define NFH_T_WH_NS 15
`define NFH_T_REA_NS 35
`define NFH_T_WB_NS 100
`define NFH_SYNC_CYC 4
`define NFH_SETUP_CYC ((`NFH_T_SETUP_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_WP_CYC ((`NFH_T_WP_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_WH_CYC ((`NFH_T_WH_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_RD_CYC (((`NFH_T_REA_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS) + `NFH_SYNC_CYC)
`define NFH_WB_CYC ((`NFH_T_WB_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)

`endif

// ### nfh_pkg.sv
package nfh_pkg;

    typedef enum logic [2:0] {
        NFH_OP_CMD = 3'h0,
        NFH_OP_ADDR4 = 3'h1,
        NFH_OP_ADDR3 = 3'h2,
        NFH_OP_WDATA = 3'h3,
        NFH_OP_RDATA = 3'h4,
        NFH_OP_WAIT = 3'h5
    } nfh_op_t;

    typedef enum logic [4:0] {
        NFH_S_IDLE = 5'b00001,
        NFH_S_SETUP = 5'b00010,
        NFH_S_LOW = 5'b00100,
        NFH_S_HIGH = 5'b01000,
        NFH_S_WAIT = 5'b10000
    } nfh_state_t;

    typedef struct packed {
        logic cle;
        logic ale;
        logic ce_n;
        logic we_n;
        logic read_strobe_low;
        logic wp_n;
        logic dq_oe_n;
        logic [7:0] dq;
    } nfh_pins_t;

endpackage : nfh_pkg

// ### nfh_ctrl.sv
// How it works
// - Byte address of 26 bits goes out in four cycles, column then rows.
// - Fourth address cycle carries top row bit on line zero, others low.
// - Read and program take four address cycles; erase takes three row cycles.
// - Bytes are written by pulsing write strobe low with chip select low.
// - Command latch routes to commands, address latch to address, neither means data.
// - Single-plane program is 80h, address, data, then confirm 10h.
// - First to third plane loads end with 11h; the last uses true code.
// - Erase is 60h with rows, repeated per plane, then one D0h.
// - After multi-plane program or erase, status is read with 71h.
// - No command code outside the defined set is ever written.
`timescale 1ns/1ns
`include "nfh_map.svh"

module nfh_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output nfh_pkg::nfh_pins_t pins_o,
    input wire logic [7:0] dq_i,
    input wire logic rb_i
);
    import nfh_pkg::*;

    // ==========================================
    // Helpers
    function automatic logic cmd_legal(input logic [7:0] c);
        unique case (c)
            `NFH_C_READ_A, `NFH_C_READ_B, `NFH_C_READ_CB, `NFH_C_READ_SP,
            `NFH_C_ID, `NFH_C_RESET, `NFH_C_PROG, `NFH_C_TRUE, `NFH_C_DUMMY,
            `NFH_C_COPY, `NFH_C_ERASE, `NFH_C_ERCONF, `NFH_C_STAT,
            `NFH_C_MSTAT: cmd_legal = 1'b1;
            default: cmd_legal = 1'b0;
        endcase
    endfunction : cmd_legal

    function automatic logic busy_ok(input logic [7:0] c);
        busy_ok = (c == `NFH_C_RESET) || (c == `NFH_C_STAT) || (c == `NFH_C_MSTAT);
    endfunction : busy_ok

    // Bit 8 is skipped: the read command picks the half
    function automatic logic [7:0] addr_byte(input logic [25:0] a, input logic [1:0] i);
        unique case (i)
            2'h0: addr_byte = a[7:0];
            2'h1: addr_byte = a[16:9];
            2'h2: addr_byte = a[24:17];
            default: addr_byte = {7'h00, a[25]};
        endcase
    endfunction : addr_byte

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // ==========================================
    // State
    nfh_state_t state_q;
    nfh_op_t op_q;
    nfh_pins_t pins_q;
    logic [1:0] idx_q;
    logic [7:0] cnt_q;
    logic [1:0] cfg_q;
    logic [25:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic err_q;
    logic multi_q;
    logic erase_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [2:0] rb_s_q;
    logic rb_ready_q;
    logic [7:0] dq_s1_q;
    logic [7:0] dq_s2_q;
    logic [7:0] dq_s3_q;
    logic [7:0] dq_q;
    logic [2:0] ale_cnt_q;

    logic wb_req;
    logic go;
    logic idle;
    logic [7:0] cmd_in;
    logic [2:0] op_in;
    logic [7:0] cmd_eff;
    logic launch_ok;
    logic [31:0] stat_word;

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign idle = (state_q == NFH_S_IDLE);
    assign go = wb_req && wb_we_i && (wb_adr_i == `NFH_REG_CTRL);
    assign cmd_in = wb_dat_i[`NFH_CTRL_CMD_MSB:0];
    assign op_in = wb_dat_i[`NFH_CTRL_OP_MSB:`NFH_CTRL_OP_LSB];
    // Plain status after multi-plane work would lose per-plane results
    assign cmd_eff = (cmd_in == `NFH_C_STAT && multi_q) ? `NFH_C_MSTAT : cmd_in;

    always_comb
    begin
        launch_ok = go && idle;
        if (op_in > 3'(NFH_OP_WAIT))
        begin
            launch_ok = 1'b0;
        end
        if (op_in == 3'(NFH_OP_CMD))
        begin
            if (!cmd_legal(cmd_in))
            begin
                launch_ok = 1'b0;
            end
            if (!rb_ready_q && !busy_ok(cmd_in))
            begin
                launch_ok = 1'b0;
            end
        end
    end

    assign stat_word = {28'h0000000, multi_q, err_q, rb_ready_q, !idle};

    // ==========================================
    // Pin synchronisers, change taken once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rb_s_q <= 3'h0;
            rb_ready_q <= 1'b0;
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
            dq_s3_q <= 8'h00;
            dq_q <= 8'h00;
        end
        else
        begin
            rb_s_q <= {rb_s_q[1:0], rb_i};
            if (rb_s_q[1] == rb_s_q[2])
            begin
                rb_ready_q <= rb_s_q[2];
            end
            dq_s1_q <= dq_i;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
            if (dq_s2_q == dq_s3_q)
            begin
                dq_q <= dq_s3_q;
            end
        end
    end

    // ==========================================
    // Wishbone slave: one-cycle ack, unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= wb_req;
            if (wb_req && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    `NFH_REG_ADDR: dat_q <= {6'h00, addr_q};
                    `NFH_REG_DATA: dat_q <= {24'h000000, rdata_q};
                    `NFH_REG_STAT: dat_q <= stat_word;
                    `NFH_REG_CFG: dat_q <= {30'h00000000, cfg_q};
                    default: dat_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Address and data are frozen while a sequence runs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_q <= `NFH_CFG_RST;
            addr_q <= 26'h0000000;
            wdata_q <= 8'h00;
        end
        else if (wb_req && wb_we_i)
        begin
            if (wb_adr_i == `NFH_REG_CFG)
            begin
                cfg_q <= 2'(merge({30'h00000000, cfg_q}, wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == `NFH_REG_ADDR && idle)
            begin
                addr_q <= 26'(merge({6'h00, addr_q}, wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == `NFH_REG_DATA && idle)
            begin
                wdata_q <= 8'(merge({24'h000000, wdata_q}, wb_dat_i, wb_sel_i));
            end
        end
    end

    // Refusal flag: set wins over write-one-to-clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            err_q <= 1'b0;
        end
        else if (go && !launch_ok)
        begin
            err_q <= 1'b1;
        end
        else if (wb_req && wb_we_i && wb_adr_i == `NFH_REG_STAT && wb_sel_i[0]
                 && wb_dat_i[`NFH_STAT_ERR])
        begin
            err_q <= 1'b0;
        end
    end

    // Multi-plane tracking for status substitution
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            multi_q <= 1'b0;
            erase_q <= 1'b0;
        end
        else if (launch_ok && op_in == 3'(NFH_OP_CMD))
        begin
            if (cmd_eff == `NFH_C_MSTAT || cmd_eff == `NFH_C_RESET)
            begin
                multi_q <= 1'b0;
            end
            else if (cmd_eff == `NFH_C_DUMMY)
            begin
                multi_q <= 1'b1;
            end
            else if (cmd_eff == `NFH_C_ERASE && erase_q)
            begin
                multi_q <= 1'b1;
            end
            if (cmd_eff == `NFH_C_ERASE)
            begin
                erase_q <= 1'b1;
            end
            else if (cmd_eff == `NFH_C_ERCONF || cmd_eff == `NFH_C_RESET)
            begin
                erase_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // Strobe sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= NFH_S_IDLE;
            op_q <= NFH_OP_CMD;
            idx_q <= 2'h0;
            cnt_q <= 8'h00;
            pins_q <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, read_strobe_low: 1'b1,
                        wp_n: 1'b0, dq_oe_n: 1'b1, dq: 8'h00};
        end
        else
        begin
            pins_q.wp_n <= cfg_q[`NFH_CFG_WREN];
            unique case (state_q)
                NFH_S_IDLE:
                begin
                    pins_q.ce_n <= !cfg_q[`NFH_CFG_CE];
                    if (launch_ok)
                    begin
                        op_q <= nfh_op_t'(op_in);
                        pins_q.ce_n <= 1'b0;
                        state_q <= NFH_S_SETUP;
                        cnt_q <= 8'(`NFH_SETUP_CYC - 1);
                        unique case (nfh_op_t'(op_in))
                            NFH_OP_CMD:
                            begin
                                pins_q.cle <= 1'b1;
                                pins_q.dq <= cmd_eff;
                                pins_q.dq_oe_n <= 1'b0;
                            end
                            NFH_OP_ADDR4:
                            begin
                                pins_q.ale <= 1'b1;
                                idx_q <= 2'h0;
                                pins_q.dq <= addr_byte(addr_q, 2'h0);
                                pins_q.dq_oe_n <= 1'b0;
                            end
                            NFH_OP_ADDR3:
                            begin
                                pins_q.ale <= 1'b1;
                                idx_q <= 2'h1;
                                pins_q.dq <= addr_byte(addr_q, 2'h1);
                                pins_q.dq_oe_n <= 1'b0;
                            end
                            NFH_OP_WDATA:
                            begin
                                pins_q.dq <= wdata_q;
                                pins_q.dq_oe_n <= 1'b0;
                            end
                            NFH_OP_RDATA:
                            begin
                                pins_q.dq_oe_n <= 1'b1;
                            end
                            default:
                            begin
                                state_q <= NFH_S_WAIT;
                                cnt_q <= 8'(`NFH_WB_CYC - 1);
                            end
                        endcase
                    end
                end
                NFH_S_SETUP:
                begin
                    if (cnt_q == 8'h00)
                    begin
                        state_q <= NFH_S_LOW;
                        if (op_q == NFH_OP_RDATA)
                        begin
                            pins_q.read_strobe_low <= 1'b0;
                            cnt_q <= 8'(`NFH_RD_CYC - 1);
                        end
                        else
                        begin
                            pins_q.we_n <= 1'b0;
                            cnt_q <= 8'(`NFH_WP_CYC - 1);
                        end
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                NFH_S_LOW:
                begin
                    if (cnt_q == 8'h00)
                    begin
                        pins_q.we_n <= 1'b1;
                        pins_q.read_strobe_low <= 1'b1;
                        state_q <= NFH_S_HIGH;
                        cnt_q <= 8'(`NFH_WH_CYC - 1);
                    end
                    else
                    begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                NFH_S_HIGH:
                begin
                    if (cnt_q != 8'h00)
                    begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                    else if ((op_q == NFH_OP_ADDR4 || op_q == NFH_OP_ADDR3) && idx_q != 2'h3)
                    begin
                        idx_q <= idx_q + 2'h1;
                        pins_q.dq <= addr_byte(addr_q, idx_q + 2'h1);
                        pins_q.we_n <= 1'b0;
                        state_q <= NFH_S_LOW;
                        cnt_q <= 8'(`NFH_WP_CYC - 1);
                    end
                    else
                    begin
                        pins_q.cle <= 1'b0;
                        pins_q.ale <= 1'b0;
                        pins_q.dq_oe_n <= 1'b1;
                        state_q <= NFH_S_IDLE;
                    end
                end
                NFH_S_WAIT:
                begin
                    if (cnt_q != 8'h00)
                    begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                    else if (rb_ready_q)
                    begin
                        state_q <= NFH_S_IDLE;
                    end
                end
                default:
                begin
                    state_q <= NFH_S_IDLE;
                end
            endcase
        end
    end

    // Byte is taken at the end of the read strobe low phase
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_q <= 8'h00;
        end
        else if (state_q == NFH_S_LOW && cnt_q == 8'h00 && op_q == NFH_OP_RDATA)
        begin
            rdata_q <= dq_q;
        end
    end

    // Address strobe count, read only by checks
    always_ff @(posedge clk_i)
    begin
        if (rst_i || launch_ok)
        begin
            ale_cnt_q <= 3'h0;
        end
        else if (state_q == NFH_S_LOW && cnt_q == 8'h00 && pins_q.ale)
        begin
            ale_cnt_q <= ale_cnt_q + 3'h1;
        end
    end

    assign pins_o = pins_q;
    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_we_under_ce: assert property (!pins_q.we_n |-> !pins_q.ce_n)
        else $error("write strobe low without chip select");
    chk_we_low_width: assert property ($fell(pins_q.we_n) |-> !pins_q.we_n [*2])
        else $error("write strobe pulse too short");
    chk_latch_exclusive: assert property (!(pins_q.cle && pins_q.ale))
        else $error("command and address latch both high");
    chk_top_row_pad: assert property (
        pins_q.ale && !pins_q.we_n && idx_q == 2'h3 |-> pins_q.dq[7:1] == 7'h00)
        else $error("upper lines not low in fourth address cycle");
    chk_four_addr: assert property (
        state_q == NFH_S_HIGH && $past(state_q) == NFH_S_LOW && op_q == NFH_OP_ADDR4
        && idx_q == 2'h3 |-> ale_cnt_q == 3'h4)
        else $error("column and row load is not four cycles");
    chk_three_rows: assert property (
        state_q == NFH_S_HIGH && $past(state_q) == NFH_S_LOW && op_q == NFH_OP_ADDR3
        && idx_q == 2'h3 |-> ale_cnt_q == 3'h3)
        else $error("row-only load is not three cycles");
    chk_bad_cmd_refused: assert property (
        go && idle && op_in == 3'(NFH_OP_CMD) && !cmd_legal(cmd_in)
        |=> state_q == NFH_S_IDLE && err_q)
        else $error("undefined command was not refused");
    chk_busy_refused: assert property (
        go && idle && op_in == 3'(NFH_OP_CMD) && !rb_ready_q && !busy_ok(cmd_in)
        |=> state_q == NFH_S_IDLE && err_q && pins_q.we_n)
        else $error("command sent while device busy");
    chk_multi_status: assert property (
        go && idle && op_in == 3'(NFH_OP_CMD) && cmd_in == `NFH_C_STAT && multi_q
        && rb_ready_q |=> pins_q.cle && pins_q.dq == `NFH_C_MSTAT)
        else $error("plain status used after multi-plane work");

endmodule : nfh_ctrl

// ### nfh_dev.sv
`timescale 1ns/1ns

module nfh_dev (
    input wire logic clk_i,
    input wire nfh_pkg::nfh_pins_t pins_i,
    output logic [7:0] dq_o,
    output logic rb_o
);
    import nfh_pkg::*;
    logic [9:0] cap_q[$];
    logic [7:0] cmd_q;
    logic [9:0] col;
    logic [16:0] row_q;
    logic [1:0] src_plane;
    logic cb_bad;
    logic [3:0] pl_fail;
    int acnt;
    int busy;
    int k;

    // Page address over 131072 pages, 32 pages a block, 4096 blocks
    function automatic logic [1:0] plane_of(input logic [16:0] r);
        plane_of = r[6:5];
    endfunction : plane_of

    initial
    begin
        dq_o = 8'h00;
        cmd_q = 8'h00;
        col = 10'h000;
        row_q = 17'h00000;
        src_plane = 2'h0;
        cb_bad = 1'b0;
        pl_fail = 4'h0;
        acnt = 0;
        busy = 0;
        k = 0;
    end

    assign rb_o = (busy == 0);
    // Non-blocking so the controller never races the busy line at an edge
    always @(posedge clk_i) if (busy > 0) busy <= busy - 1;

    // ==========================================
    // Byte capture on the write strobe rising edge
    always @(posedge pins_i.we_n)
    begin
        if (!pins_i.ce_n && pins_i.cle && (busy == 0 || pins_i.dq inside {8'hff, 8'h70, 8'h71}))
        begin
            if (pins_i.dq == 8'h8a) src_plane = plane_of(row_q);
            if (pins_i.dq inside {8'h10, 8'h11} && cmd_q == 8'h8a)
                cb_bad = (plane_of(row_q) != src_plane);
            cap_q.push_back({2'b10, pins_i.dq});
            cmd_q = pins_i.dq;
            acnt = 0;
            col = (pins_i.dq == 8'h01) ? 10'h100 :
                  (pins_i.dq == 8'h50) ? 10'h200 : 10'h000;
            if (pins_i.dq inside {8'h10, 8'hd0} && pins_i.wp_n) busy = 80;
        end
        else if (!pins_i.ce_n && pins_i.ale)
        begin
            k = acnt - ((cmd_q == 8'h60) ? 0 : 1);
            if (acnt < ((cmd_q == 8'h60) ? 3 : 4))
            begin
                cap_q.push_back({2'b01, pins_i.dq});
                if (k == 0) row_q[7:0] = pins_i.dq;
                if (k == 1) row_q[15:8] = pins_i.dq;
                if (k == 2) row_q[16] = pins_i.dq[0];
            end
            acnt++;
        end
        else if (!pins_i.ce_n && !pins_i.cle) cap_q.push_back({2'b00, pins_i.dq});
    end

    // ==========================================
    // Read-out
    always @(negedge pins_i.read_strobe_low)
    begin
        if (cmd_q inside {8'h70, 8'h71})
            dq_o = {1'b0, busy == 0, 1'b0, pl_fail, |pl_fail};
        else
            dq_o = 8'(8'h3c + col);
        col = (col == 10'd527) ? 10'h000 : col + 10'h001;
    end
    // Released bus must not keep the last byte
    always @(posedge pins_i.read_strobe_low) dq_o = ~dq_o;
endmodule : nfh_dev

// ### tb_top.sv
`timescale 1ns/1ns
`include "nfh_map.svh"

module tb_top;
    import nfh_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, rb, wb_ack_o;
    logic [7:0] adr, dq;
    logic [31:0] wdat, rdat, wb_dat_o, a, d;
    logic [3:0] sel;
    logic [63:0] ex;
    nfh_pins_t pins;
    logic [63:0] exp_q[$];
    int err_total, tests_run, seed, cyc_n;

    nfh_ctrl nfh_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(wb_ack_o), .pins_o(pins), .dq_i(dq), .rb_i(rb));
    nfh_dev nfh_dev_inst (.clk_i(clk_i), .pins_i(pins), .dq_o(dq), .rb_o(rb));

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task fail(input string m);
        $display("wrong value at %0t: %s", $time, m);
        err_total++;
    endtask : fail

    task close_out;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // ==========================================
    // Bus master
    task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        sel <= 4'hf;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e});
        wb(1'b0, ad, 32'h0);
    endtask : rd

    // Mask zero marks a poll with nothing to compare
    task poll(input int b, input logic v);
        for (int i = 0; i < 300; i++)
        begin
            rd(`NFH_REG_STAT, 32'h0, 32'h0);
            if (rdat[b] === v) return;
        end
        fail("no completion");
    endtask : poll

    task run(input logic [2:0] op, input logic [7:0] c);
        wb(1'b1, `NFH_REG_CTRL, {21'h0, op, c});
        poll(0, 1'b0);
    endtask : run

    task cap(input logic [9:0] e);
        tests_run++;
        if (nfh_dev_inst.cap_q.size() == 0)
            fail("missing pin byte");
        else if (nfh_dev_inst.cap_q.pop_front() !== e)
            fail("pin byte");
    endtask : cap

    task rows;
        cap({2'b01, a[16:9]});
        cap({2'b01, a[24:17]});
        cap({2'b01, 7'h0, a[25]});
    endtask : rows

    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && we === 1'b0 && cyc === 1'b1 && exp_q.size() > 0)
        begin
            ex = exp_q.pop_front();
            if (ex[63:32] != 32'h0) tests_run++;
            if ((wb_dat_o & ex[63:32]) !== (ex[31:0] & ex[63:32])) fail("read data");
        end
    end

    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n > 30000)
        begin
            err_total++;
            close_out;
        end
    end

    initial
    begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        sel = 4'h0;
        err_total = 0;
        tests_run = 0;
        cyc_n = 0;
        seed = 32'h9891;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        tests_run++;
        if (pins.ce_n !== 1'b1 || pins.wp_n !== 1'b0 || pins.dq_oe_n !== 1'b1) fail("idle pins");
        repeat (4) @(posedge clk_i);
        rd(`NFH_REG_STAT, 32'h2, 32'hf);
        rd(8'h20, 32'h0, 32'hffffffff);
        wb(1'b1, `NFH_REG_CFG, 32'h3);
        rd(`NFH_REG_CFG, 32'h3, 32'h3);
        a = $random(seed) & 32'h3ffffff;
        run(3'h0, 8'h01);
        cap({2'b10, 8'h01});
        wb(1'b1, `NFH_REG_ADDR, a);
        run(3'h1, 8'h00);
        cap({2'b01, a[7:0]});
        rows;
        run(3'h4, 8'h00);
        rd(`NFH_REG_DATA, 32'h3c, 32'hff);
        run(3'h4, 8'h00);
        rd(`NFH_REG_DATA, 32'h3d, 32'hff);
        run(3'h0, 8'h60);
        cap({2'b10, 8'h60});
        run(3'h2, 8'h00);
        rows;
        run(3'h0, 8'hd0);
        cap({2'b10, 8'hd0});
        run(3'h0, 8'h00);
        rd(`NFH_REG_STAT, 32'h4, 32'h6);
        wb(1'b1, `NFH_REG_STAT, 32'h4);
        run(3'h0, 8'h70);
        cap({2'b10, 8'h70});
        run(3'h5, 8'h00);
        rd(`NFH_REG_STAT, 32'h2, 32'h3);
        run(3'h0, 8'h80);
        cap({2'b10, 8'h80});
        run(3'h1, 8'h00);
        cap({2'b01, a[7:0]});
        rows;
        d = $random(seed);
        wb(1'b1, `NFH_REG_DATA, d);
        run(3'h3, 8'h00);
        cap({2'b00, d[7:0]});
        run(3'h0, 8'h11);
        cap({2'b10, 8'h11});
        run(3'h0, 8'h70);
        cap({2'b10, 8'h71});
        run(3'h4, 8'h00);
        rd(`NFH_REG_DATA, 32'h40, 32'hff);
        run(3'h0, 8'h8a);
        cap({2'b10, 8'h8a});
        run(3'h1, 8'h00);
        cap({2'b01, a[7:0]});
        rows;
        run(3'h0, 8'h10);
        cap({2'b10, 8'h10});
        tests_run++;
        if (nfh_dev_inst.cb_bad !== 1'b0) fail("copy-back plane");
        run(3'h0, 8'h42);
        rd(`NFH_REG_STAT, 32'h4, 32'h4);
        tests_run++;
        if (nfh_dev_inst.cap_q.size() != 0) fail("stray pin byte");
        repeat (4) @(posedge clk_i);
        close_out;
    end
endmodule : tb_top
